//--- rtl/uart_baud_consts.vh
// register map, field positions and reset values of the uart channel block
`ifndef UART_BAUD_CONSTS_VH
`define UART_BAUD_CONSTS_VH

// channel select sits in address bits 11:10, offset in 9:0
`define CH_SEL_HI      11
`define CH_SEL_LO      10
`define OFF_HI         9
`define TOP_HI         15
`define TOP_LO         12

// per-channel offsets
`define OFF_DATA       10'h000
`define OFF_MODEM      10'h004
`define OFF_DIV_LO     10'h008
`define OFF_DIV_HI     10'h009
`define OFF_DIV_FRAC   10'h00a
`define OFF_MODE       10'h00b
`define OFF_STATUS     10'h00c

// reset values
`define RST_MODEM      8'h00
`define RST_DIV_LO     8'h01
`define RST_DIV_HI     8'h00
`define RST_DIV_FRAC   4'h0
`define RST_MODE       2'h0

// fields
`define PRESCALE_BIT   7
`define MODE_8X        0
`define MODE_4X        1
`define SIZE_BYTE      2'h0

// fifo geometry: 256 bytes each way
`define FIFO_AW        8
`define PRESCALE_LAST  2'h3
`define SPB_16X        4'hf
`define SPB_8X         4'h7
`define SPB_4X         4'h3

`endif

//--- rtl/uart_fractional_baud_generator.v
// four uart channels: byte data port, fifos, prescaler and fractional baud generator
//
// Behaviour
// R1 - a byte write to the data address fills the tx holding fifo, a read pops the rx one.
// R2 - the data port takes byte accesses only; wider accesses are refused with an error pulse.
// R3 - four independent channels, each with 256-byte tx and rx fifos and its own generator.
// R4 - modem control bit 7 makes the prescaler divide the clock by 4 instead of 1.
// R5 - the generator divides the prescaled clock by a divisor from 1 to 65535 15/16 in 1/16 steps.
// R6 - the divided output is the sampling tick, 16, 8 or 4 per serial bit.
// R7 - after reset the divisor is 1: low byte 1, high byte 0, fraction 0.
// R8 - high and low divisor bytes form the integer part, the fraction register the fractional part.
// R9 - only the low four fraction bits exist and give 0/16 to 15/16.
// R10 - with the prescaler on, the bit rate is a quarter of that with the same divisor.
// R11 - for one divisor, 8x sampling doubles the bit rate and 4x quadruples it.
// R12 - in 8x or 4x mode an odd fraction may jitter the bit time by 1/16.
// R13 - software picks the divisor as prescaled clock over bit rate times 16, 8 or 4.
// R14 - software writes the high byte, low byte and rounded fraction times sixteen.
// R15 - ticks come on average every integer plus fraction/16 prescaled cycles, spread evenly.
`include "uart_baud_consts.vh"
`default_nettype none

module uart_fractional_baud_generator (
    input  wire        ref_clk,
    input  wire        nrst,
    input  wire [15:0] bus_addr,
    input  wire        bus_wr,
    input  wire        bus_rd,
    input  wire [1:0]  bus_size,
    input  wire [7:0]  bus_wdata,
    output reg  [7:0]  bus_rdata,
    output reg         bus_ack,
    output reg         bus_err,
    input  wire [3:0]  tx_pop,
    output wire [31:0] tx_byte,
    output wire [3:0]  tx_avail,
    input  wire [3:0]  rx_push,
    input  wire [31:0] rx_byte,
    output wire [3:0]  sample_tick,
    output wire [3:0]  bit_tick
);

    wire        is_byte;
    wire        in_map;
    wire [9:0]  off;
    wire [31:0] rd_all;
    reg  [7:0]  rd_sel;

    // wider accesses never reach the channels
    assign is_byte = (bus_size == `SIZE_BYTE); // R2
    assign in_map  = (bus_addr[`TOP_HI:`TOP_LO] == 4'h0);
    assign off     = bus_addr[`OFF_HI:0];

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : ch // R3
            wire        sel;
            wire        wr_ok;
            wire        rd_ok;
            reg  [7:0]  modem_control_q;
            reg  [7:0]  div_lo_q;
            reg  [7:0]  div_hi_q;
            reg  [3:0]  div_frac_q;
            reg  [1:0]  mode_q;
            reg  [7:0]  tx_mem [0:255];
            reg  [7:0]  rx_mem [0:255];
            reg  [8:0]  tx_wp_q;
            reg  [8:0]  tx_rp_q;
            reg  [8:0]  rx_wp_q;
            reg  [8:0]  rx_rp_q;
            reg  [7:0]  tx_head_q;
            reg         tx_avail_q;
            wire        tx_full;
            wire        tx_empty;
            wire        rx_full;
            wire        rx_empty;
            wire        tx_push;
            wire        tx_take;
            wire        rx_take;
            wire        rx_load;
            wire [8:0]  tx_rp_d;
            wire [8:0]  tx_wp_d;
            reg  [7:0]  rd_val;
            reg  [1:0]  pre_q;
            wire        pre_en;
            reg  [16:0] cnt_q;
            reg  [3:0]  acc_q;
            wire [4:0]  acc_sum;
            wire [15:0] div_int;
            wire [16:0] period;
            wire        hit;
            reg         tick_q;
            reg  [3:0]  sub_q;
            reg  [3:0]  spb_last;
            reg         bit_q;

            assign sel   = in_map && (bus_addr[`CH_SEL_HI:`CH_SEL_LO] == g);
            assign wr_ok = bus_wr && sel && is_byte; // R2
            assign rd_ok = bus_rd && sel && is_byte; // R2

            // fifo flags from wrap-bit pointers
            assign tx_full  = (tx_wp_q[7:0] == tx_rp_q[7:0]) && (tx_wp_q[8] != tx_rp_q[8]);
            assign tx_empty = (tx_wp_q == tx_rp_q);
            assign rx_full  = (rx_wp_q[7:0] == rx_rp_q[7:0]) && (rx_wp_q[8] != rx_rp_q[8]);
            assign rx_empty = (rx_wp_q == rx_rp_q);

            // a write into a full fifo is dropped, a read of an empty one returns 0
            assign tx_push = wr_ok && (off == `OFF_DATA) && !tx_full; // R1
            assign tx_take = tx_pop[g] && !tx_empty;
            assign rx_take = rd_ok && (off == `OFF_DATA) && !rx_empty; // R1
            assign rx_load = rx_push[g] && !rx_full;
            assign tx_rp_d = tx_rp_q + {8'h00, tx_take};
            assign tx_wp_d = tx_wp_q + {8'h00, tx_push};

            // control registers
            always @(posedge ref_clk) begin
                if (!nrst) begin
                    modem_control_q <= `RST_MODEM;
                    div_lo_q        <= `RST_DIV_LO; // R7
                    div_hi_q        <= `RST_DIV_HI; // R7
                    div_frac_q      <= `RST_DIV_FRAC; // R7
                    mode_q          <= `RST_MODE;
                end else if (wr_ok) begin
                    case (off)
                        `OFF_MODEM:    modem_control_q <= bus_wdata;
                        `OFF_DIV_LO:   div_lo_q        <= bus_wdata;
                        `OFF_DIV_HI:   div_hi_q        <= bus_wdata;
                        `OFF_DIV_FRAC: div_frac_q      <= bus_wdata[3:0]; // R9
                        `OFF_MODE:     mode_q          <= bus_wdata[1:0];
                        default:       mode_q          <= mode_q;
                    endcase
                end
            end

            // fifo storage has no reset, only the pointers do
            always @(posedge ref_clk) begin
                if (tx_push) begin
                    tx_mem[tx_wp_q[7:0]] <= bus_wdata; // R1
                end
                if (rx_load) begin
                    rx_mem[rx_wp_q[7:0]] <= rx_byte[8*g +: 8];
                end
            end

            // pointers and the registered head byte for the frame engine
            always @(posedge ref_clk) begin
                if (!nrst) begin
                    tx_wp_q    <= 9'h000;
                    tx_rp_q    <= 9'h000;
                    rx_wp_q    <= 9'h000;
                    rx_rp_q    <= 9'h000;
                    tx_head_q  <= 8'h00;
                    tx_avail_q <= 1'b0;
                end else begin
                    tx_wp_q    <= tx_wp_d;
                    tx_rp_q    <= tx_rp_d;
                    rx_wp_q    <= rx_wp_q + {8'h00, rx_load};
                    rx_rp_q    <= rx_rp_q + {8'h00, rx_take};
                    tx_avail_q <= (tx_wp_d != tx_rp_d);
                    // bypass so a byte written into an empty fifo shows at once
                    if (tx_push && (tx_wp_q[7:0] == tx_rp_d[7:0])) begin
                        tx_head_q <= bus_wdata;
                    end else begin
                        tx_head_q <= tx_mem[tx_rp_d[7:0]];
                    end
                end
            end

            // read mux for this channel
            always @* begin
                case (off)
                    `OFF_DATA:     rd_val = rx_empty ? 8'h00 : rx_mem[rx_rp_q[7:0]]; // R1
                    `OFF_MODEM:    rd_val = modem_control_q;
                    `OFF_DIV_LO:   rd_val = div_lo_q;
                    `OFF_DIV_HI:   rd_val = div_hi_q;
                    `OFF_DIV_FRAC: rd_val = {4'h0, div_frac_q}; // R9
                    `OFF_MODE:     rd_val = {6'h00, mode_q};
                    `OFF_STATUS:   rd_val = {4'h0, rx_full, tx_empty, tx_full, !rx_empty};
                    default:       rd_val = 8'h00;
                endcase
            end
            assign rd_all[8*g +: 8] = rd_val;

            // prescaler: every clock, or one in four
            assign pre_en = modem_control_q[`PRESCALE_BIT] ?
                            (pre_q == `PRESCALE_LAST) : 1'b1; // R4 R10
            always @(posedge ref_clk) begin
                if (!nrst) begin
                    pre_q <= 2'h0;
                end else begin
                    pre_q <= pre_q + 2'h1;
                end
            end

            // fractional divider: the fraction accumulator adds one extra
            // cycle on each carry, so 16 periods sum to 16*int + frac
            assign div_int = {div_hi_q, div_lo_q}; // R8
            assign acc_sum = {1'b0, acc_q} + {1'b0, div_frac_q}; // R15
            // zero integer is outside the legal range; it behaves as 1
            assign period  = ((div_int == 16'h0000) ? 17'h00001 : {1'b0, div_int})
                             + {16'h0000, acc_sum[4]}; // R5 R15
            assign hit     = pre_en && (cnt_q <= 17'h00001);

            always @(posedge ref_clk) begin
                if (!nrst) begin
                    cnt_q  <= 17'h00000;
                    acc_q  <= 4'h0;
                    tick_q <= 1'b0;
                end else begin
                    tick_q <= hit; // R6
                    if (wr_ok && (off >= `OFF_DIV_LO) && (off <= `OFF_DIV_FRAC)) begin
                        // restart so a new divisor takes effect cleanly
                        cnt_q <= 17'h00000;
                        acc_q <= 4'h0;
                    end else if (hit) begin
                        cnt_q <= period; // R5
                        acc_q <= acc_sum[3:0]; // R15
                    end else if (pre_en) begin
                        cnt_q <= cnt_q - 17'h00001;
                    end
                end
            end

            // ticks per bit; in 8x/4x the fractional spread shows as bit jitter
            always @* begin
                if (mode_q[`MODE_4X]) begin
                    spb_last = `SPB_4X; // R11
                end else if (mode_q[`MODE_8X]) begin
                    spb_last = `SPB_8X; // R11
                end else begin
                    spb_last = `SPB_16X;
                end
            end

            // bit boundary counter, fed by the sampling tick
            always @(posedge ref_clk) begin
                if (!nrst) begin
                    sub_q <= 4'h0;
                    bit_q <= 1'b0;
                end else begin
                    bit_q <= 1'b0;
                    if (hit) begin
                        if (sub_q >= spb_last) begin
                            sub_q <= 4'h0;
                            bit_q <= 1'b1; // R6 R12
                        end else begin
                            sub_q <= sub_q + 4'h1;
                        end
                    end
                end
            end

            assign tx_byte[8*g +: 8] = tx_head_q;
            assign tx_avail[g]       = tx_avail_q;
            assign sample_tick[g]    = tick_q;
            assign bit_tick[g]       = bit_q;
        end
    endgenerate

    // pick the addressed channel's read value
    always @* begin
        case (bus_addr[`CH_SEL_HI:`CH_SEL_LO])
            2'h0:    rd_sel = rd_all[7:0];
            2'h1:    rd_sel = rd_all[15:8];
            2'h2:    rd_sel = rd_all[23:16];
            default: rd_sel = rd_all[31:24];
        endcase
    end

    // answer one cycle after the request; unmapped reads give 0
    always @(posedge ref_clk) begin
        if (!nrst) begin
            bus_rdata <= 8'h00;
            bus_ack   <= 1'b0;
            bus_err   <= 1'b0;
        end else begin
            bus_ack   <= (bus_rd || bus_wr) && is_byte;
            bus_err   <= (bus_rd || bus_wr) && !is_byte; // R2
            bus_rdata <= (bus_rd && is_byte && in_map) ? rd_sel : 8'h00;
        end
    end

endmodule // uart_fractional_baud_generator

`default_nettype wire

//--- verification/uart_baud_props.sv
// port checker for the uart channel block
`default_nettype none
module uart_baud_props (
    input wire logic        ref_clk,
    input wire logic        nrst,
    input wire logic [15:0] bus_addr,
    input wire logic        bus_wr,
    input wire logic        bus_rd,
    input wire logic [1:0]  bus_size,
    input wire logic [7:0]  bus_wdata,
    input wire logic [7:0]  bus_rdata,
    input wire logic        bus_ack,
    input wire logic        bus_err,
    input wire logic [31:0] tx_byte,
    input wire logic [3:0]  tx_avail
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // request qualifiers
    wire req = bus_rd | bus_wr;
    wire wide = bus_size != 2'h0;
    wire wr0 = bus_wr && bus_addr == 16'h0000;
    ack_after_req_a: assert property (req && !wide |=> bus_ack && !bus_err)
        else $error("byte access not acked");
    err_after_wide_a: assert property (req && wide |=> bus_err && !bus_ack)
        else $error("wide access not refused");
    no_spurious_a: assert property (bus_ack || bus_err |-> $past(req))
        else $error("answer without request");
    idle_quiet_a: assert property (!req |=> !bus_ack && !bus_err)
        else $error("answer while idle");
    rdata_idle_a: assert property (!bus_ack |-> bus_rdata == 8'h00)
        else $error("read data outside ack");
    tx_fill_a: assert property (wr0 && !wide && !tx_avail[0]
        |=> tx_avail[0] && tx_byte[7:0] == $past(bus_wdata))
        else $error("write missed transmit holding");
    wide_no_fill_a: assert property (wr0 && wide && !tx_avail[0] |=> !tx_avail[0])
        else $error("wide write filled transmit");
    unmapped_zero_a: assert property (bus_rd && !wide && bus_addr[15:12] != 4'h0
        |=> bus_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule // uart_baud_props
`default_nettype wire

//--- verification/uart_far_end.sv
// remote serial side model: drains transmit bytes, feeds received ones
`default_nettype none
module uart_far_end (
    input  wire logic        ref_clk,
    input  wire logic [31:0] tx_byte,
    input  wire logic [3:0]  tx_avail,
    output var  logic [3:0]  tx_pop,
    output var  logic [3:0]  rx_push,
    output var  logic [31:0] rx_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        tx_pop = 4'h0;
        rx_push = 4'h0;
        rx_byte = 32'h0;
    end
    // one received byte per lane; lanes invert after so stale data never matches
    task automatic push(input int ch, input logic [7:0] d);
        @(negedge ref_clk);
        rx_byte[8*ch +: 8] = d;
        rx_push[ch] = 1'b1;
        @(negedge ref_clk);
        rx_push = 4'h0;
        rx_byte = ~rx_byte;
    endtask
    // takes the head byte only when one is there
    task automatic pop(input int ch, output logic [7:0] d);
        @(negedge ref_clk);
        d = tx_byte[8*ch +: 8];
        tx_pop[ch] = tx_avail[ch];
        @(negedge ref_clk);
        tx_pop = 4'h0;
    endtask
endmodule // uart_far_end
`default_nettype wire

//--- verification/uart_fractional_baud_generator_bench.sv
// self-checking bench for the uart channel block
`include "uart_baud_consts.vh"
`default_nettype none
module uart_fractional_baud_generator_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk, nrst, bus_wr, bus_rd, bus_ack, bus_err;
    logic [15:0] bus_addr;
    logic [1:0]  bus_size;
    logic [7:0]  bus_wdata, bus_rdata, got;
    logic [3:0]  tx_pop, tx_avail, rx_push, sample_tick, bit_tick;
    logic [31:0] tx_byte, rx_byte;
    int          n_errors = 0;
    int          cmp_count = 0;
    int          cnt;
    uart_fractional_baud_generator u_dut (.ref_clk(ref_clk), .nrst(nrst),
        .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_size(bus_size),
        .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack), .bus_err(bus_err),
        .tx_pop(tx_pop), .tx_byte(tx_byte), .tx_avail(tx_avail), .rx_push(rx_push),
        .rx_byte(rx_byte), .sample_tick(sample_tick), .bit_tick(bit_tick));
    uart_far_end u_far (.ref_clk(ref_clk), .tx_byte(tx_byte), .tx_avail(tx_avail),
        .tx_pop(tx_pop), .rx_push(rx_push), .rx_byte(rx_byte));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic tally_and_finish();
        if (n_errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // one-cycle request pulse, answer sampled in the following cycle
    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d,
                       input logic [1:0] s);
        @(negedge ref_clk);
        {bus_wr, bus_rd, bus_addr, bus_wdata, bus_size} = {w, !w, a, d, s};
        @(negedge ref_clk);
        {bus_wr, bus_rd} = 2'b00;
        got = bus_rdata;
        chk({bus_ack, bus_err}, {s == `SIZE_BYTE, s != `SIZE_BYTE});
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        acc(1'b1, a, d, `SIZE_BYTE);
    endtask
    task automatic rdc(input logic [15:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00, `SIZE_BYTE);
        chk(got, e);
    endtask
    // settle, then count channel 0 ticks over a whole number of periods
    task automatic ticks(input bit use_bit, input int n, input int e);
        cnt = 0;
        repeat (20) @(negedge ref_clk);
        repeat (n) begin
            @(negedge ref_clk);
            cnt += use_bit ? (bit_tick[0] === 1'b1) : (sample_tick[0] === 1'b1);
        end
        chk(cnt, e);
    endtask
    initial begin
        #500us;
        n_errors++;
        tally_and_finish();
    end
    initial begin
        {nrst, bus_wr, bus_rd, bus_addr, bus_wdata, bus_size} = '0;
        repeat (12) @(negedge ref_clk);
        nrst = 1'b1;
        rdc(`OFF_DIV_LO, `RST_DIV_LO);
        rdc(`OFF_DIV_HI, `RST_DIV_HI);
        rdc(`OFF_DIV_FRAC, 8'h00);
        // back-to-back channel traffic, lanes kept apart
        wr(16'h0000, 8'ha5);
        wr(16'h0800, 8'h3c);
        chk({tx_avail, tx_byte[23:16], tx_byte[7:0]}, {4'h5, 8'h3c, 8'ha5});
        u_far.pop(0, got);
        chk({got, tx_avail}, {8'ha5, 4'h4});
        acc(1'b1, 16'h0400, 8'h11, 2'h2);
        chk(tx_avail, 4'h4);
        u_far.push(0, 8'h5a);
        u_far.push(3, 8'h77);
        rdc(16'h0000, 8'h5a);
        rdc(16'h0c00, 8'h77);
        rdc(16'h0000, 8'h00);
        rdc(16'h1000, 8'h00);
        wr(`OFF_DIV_FRAC, 8'hf8);
        rdc(`OFF_DIV_FRAC, 8'h08);
        wr(`OFF_DIV_FRAC, 8'h00);
        wr(`OFF_DIV_LO, 8'h03);
        ticks(0, 60, 20);
        wr(`OFF_DIV_HI, 8'h01);
        wr(`OFF_DIV_LO, 8'h01);
        ticks(0, 2570, 10);
        wr(`OFF_DIV_HI, 8'h00);
        wr(`OFF_DIV_LO, 8'h02);
        wr(`OFF_DIV_FRAC, 8'h08);
        ticks(0, 40, 16);
        wr(`OFF_DIV_LO, 8'h01);
        wr(`OFF_DIV_FRAC, 8'h00);
        wr(`OFF_MODEM, 8'h80);
        ticks(0, 40, 10);
        ticks(1, 640, 10);
        wr(`OFF_MODEM, 8'h00);
        // sampling selects: 16x, 8x, 4x, and 4x winning over 8x
        for (int m = 0; m < 4; m++) begin
            wr(`OFF_MODE, m[7:0]);
            ticks(1, 64, (m == 0) ? 4 : (m == 1) ? 8 : 16);
        end
        // odd fraction in 8x: 2 1/16 repeats every 33 cycles with 16 ticks, 2 bits
        wr(`OFF_MODE, 8'h01);
        wr(`OFF_DIV_LO, 8'h02);
        wr(`OFF_DIV_FRAC, 8'h01);
        ticks(0, 330, 160);
        ticks(1, 330, 20);
        // mid-run reset must bring divisor and selects back to defaults (prescaler is already off)
        @(negedge ref_clk);
        nrst = 1'b0;
        repeat (3) @(negedge ref_clk);
        nrst = 1'b1;
        rdc(`OFF_DIV_LO, `RST_DIV_LO);
        rdc(`OFF_DIV_FRAC, 8'h00);
        ticks(1, 64, 4);
        tally_and_finish();
    end
endmodule // uart_fractional_baud_generator_bench
bind uart_fractional_baud_generator uart_baud_props u_props (.ref_clk(ref_clk), .nrst(nrst),
    .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_size(bus_size),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack), .bus_err(bus_err),
    .tx_byte(tx_byte), .tx_avail(tx_avail));
`default_nettype wire
